// >>> bench/net_master_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// master station: cyclic output bits and direction commands
// ----------------------------------------------------------------
module net_master_model
  import sio_pkg::*;
#(
  parameter int PHASE = 400000
)
(
  input  wire logic              aclk,
  output logic [NUM_POINTS-1:0]  remote_output_bits,
  output logic [NUM_POINTS-1:0]  channel_direction_select_bits,
  output logic                   operating_condition_apply_request,
  output logic                   initial_processing_active
);
  // all points start as inputs, select bits off
  initial
  begin
    remote_output_bits                = '0;
    channel_direction_select_bits     = '0;
    operating_condition_apply_request = 1'b0;
    initial_processing_active         = 1'b0;
  end

  // select bits on for outputs, off for inputs, inside initial processing
  task automatic init_dirs(input logic [NUM_POINTS-1:0] bits);
    @(posedge aclk);
    initial_processing_active     <= 1'b1;
    channel_direction_select_bits <= bits;
    repeat (3) @(posedge aclk);
    initial_processing_active     <= 1'b0;
  endtask : init_dirs

  // later change, only applied when the request is raised
  task automatic set_dirs(input logic [NUM_POINTS-1:0] bits, input logic apply);
    @(posedge aclk);
    channel_direction_select_bits <= bits;
    if (apply)
    begin
      @(posedge aclk);
      operating_condition_apply_request <= 1'b1;
      repeat (2) @(posedge aclk);
      operating_condition_apply_request <= 1'b0;
    end
  endtask : set_dirs

  task automatic set_remote(input logic [NUM_POINTS-1:0] bits);
    @(posedge aclk);
    remote_output_bits <= bits;
  endtask : set_remote

  // on phase held PHASE cycles, off phase PHASE+1 cycles, so no edge is lost
  task automatic pulse(input logic [NUM_POINTS-1:0] mask, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      remote_output_bits <= remote_output_bits | mask;
      repeat (PHASE) @(posedge aclk);
      remote_output_bits <= remote_output_bits & ~mask;
      repeat (PHASE) @(posedge aclk);
    end
  endtask : pulse
endmodule : net_master_model

// >>> bench/sio_output_count_fault_flags_tb.sv
`timescale 1ns/100ps
module sio_output_count_fault_flags_tb
  import sio_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                  aclk;
  logic                  aresetn = 1'b0;
  det_pins_s             pins    = '0;
  logic                  awvalid = 1'b0;
  logic                  wvalid  = 1'b0;
  logic                  bready  = 1'b0;
  logic                  arvalid = 1'b0;
  logic                  rready  = 1'b0;
  logic [AXI_AW-1:0]     awaddr  = '0;
  logic [AXI_AW-1:0]     araddr  = '0;
  logic [AXI_DW-1:0]     wdata   = '0;
  logic [3:0]            wstrb   = '0;
  logic [2:0]            prot    = '0;
  logic [NUM_POINTS-1:0] rob, sel, sop, odir, sig_lim;
  logic [NUM_PORTS-1:0]  sns_lim;
  logic                  req, ipa, mod_led, act_led, irq;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp;
  logic [AXI_DW-1:0]     rdata;
  fault_flags_s          flags;
  int                    error_cnt = 0;
  int                    compares  = 0;

  net_master_model #(.PHASE(3)) u_net_master_model (
    .aclk                              (aclk),
    .remote_output_bits                (rob),
    .channel_direction_select_bits     (sel),
    .operating_condition_apply_request (req),
    .initial_processing_active         (ipa)
  );

  // blink half period shortened so flashing shows in a few cycles
  sio_output_count_fault_flags #(.BLINK_HALF(BLINK_W'(4))) u_sio_output_count_fault_flags (
    .aclk(aclk), .aresetn(aresetn), .remote_output_bits(rob), .channel_direction_select_bits(sel),
    .operating_condition_apply_request(req), .initial_processing_active(ipa), .detector_pins(pins),
    .switched_output_points(sop), .output_direction(odir), .signal_line_limit(sig_lim),
    .sensor_supply_limit(sns_lim), .fault_flags(flags), .module_supply_led_red(mod_led),
    .actuator_supply_led_red(act_led), .irq(irq), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(prot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(prot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
  );

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // let n edges pass, then look at settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  // readies come from registers, so the negedge value is the edge value
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] r;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    bh = 1'b0;
    while (!bh)
    begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : axi_wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    rh = 1'b0;
    while (!rh)
    begin
      @(negedge aclk);
      ah = arvalid & arready;
      rh = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(nm, e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    settle(1);
    chk("irq_rst", 32'h0, irq);
    rd_chk("mask_rst", REG_IRQ_MASK, 32'h0, RESP_OKAY);
    rd_chk("cnt_rst", 8'h40, 32'h0, RESP_OKAY);
    rd_chk("unmapped", 8'h20, 32'h0, RESP_SLVERR);
    axi_wr(8'h20, 32'h1, 4'hf, RESP_SLVERR);
  endtask : t_reset

  task automatic t_dir;
    u_net_master_model.init_dirs(16'h80ff);
    settle(2);
    chk("dir_init", 16'h80ff, odir);
    u_net_master_model.set_dirs(16'hffff, 1'b0);
    settle(3);
    chk("dir_hold", 16'h80ff, odir);
    u_net_master_model.set_dirs(16'hffff, 1'b1);
    settle(2);
    chk("dir_apply", 16'hffff, odir);
    axi_wr(REG_DIR, 32'h0, 4'hf, RESP_OKAY);
    rd_chk("dir_reg", REG_DIR, 32'hffff, RESP_OKAY);
    u_net_master_model.set_dirs(16'h80ff, 1'b1);
    settle(2);
  endtask : t_dir

  task automatic t_out;
    u_net_master_model.set_remote(16'hffff);
    settle(2);
    chk("out_on", 16'h80ff, sop);
    u_net_master_model.set_remote(16'h0000);
    settle(2);
    chk("out_off", 16'h0, sop);
  endtask : t_out

  // points 0 and 15 are outputs, point 8 an input that must not count
  task automatic t_count;
    axi_wr(8'h40, 32'h0, 4'hf, RESP_OKAY);
    axi_wr(8'h60, 32'h0, 4'hf, RESP_OKAY);
    axi_wr(8'h7c, 32'h0, 4'hf, RESP_OKAY);
    u_net_master_model.pulse(16'h8101, 3);
    settle(2);
    rd_chk("cnt0", 8'h40, 32'h3, RESP_OKAY);
    rd_chk("cnt15", 8'h7c, 32'h3, RESP_OKAY);
    rd_chk("cnt8_in", 8'h60, 32'h0, RESP_OKAY);
    axi_wr(8'h40, 32'h5, 4'hf, RESP_OKAY);
    rd_chk("cnt0_nz", 8'h40, 32'h3, RESP_OKAY);
    axi_wr(8'h40, 32'h0, 4'hf, RESP_OKAY);
    rd_chk("cnt0_clr", 8'h40, 32'h0, RESP_OKAY);
  endtask : t_count

  // p and ef are {critical, actuator low, module low}; am 0 off, 1 steady, 2 flashing
  task automatic sup(input logic [2:0] p, input logic [2:0] ef, input logic ml, input int am);
    int ones;
    ones = 0;
    @(posedge aclk);
    pins.actuator_supply_critical  <= p[2];
    pins.actuator_supply_low       <= p[1];
    pins.module_sensor_supply_low  <= p[0];
    settle(4);
    chk("sup_flags", {29'h0, ef}, {29'h0, flags.actuator_supply_critical_flag,
        flags.actuator_supply_low_flag, flags.module_supply_low_flag});
    chk("mod_led", {31'h0, ml}, {31'h0, mod_led});
    repeat (12)
    begin
      @(negedge aclk);
      if (act_led === 1'b1) ones++;
    end
    chk("act_led", am, (ones == 0) ? 0 : (ones == 12) ? 1 : 2);
    rd_chk("sup_reg", REG_SUPPLY, {29'h0, ef}, RESP_OKAY);
  endtask : sup

  task automatic t_supply;
    sup(3'b001, 3'b001, 1'b1, 0);
    sup(3'b010, 3'b010, 1'b0, 2);
    sup(3'b110, 3'b110, 1'b0, 1);
    sup(3'b111, 3'b001, 1'b1, 0);
    sup(3'b000, 3'b000, 1'b0, 0);
  endtask : t_supply

  task automatic t_short;
    u_net_master_model.set_remote(16'h0008);
    @(posedge aclk);
    pins.signal_line_short   <= 16'h0008;
    pins.sensor_supply_short <= 8'h20;
    settle(4);
    chk("sig_flags", 16'h0008, flags.signal_line_short_flags);
    chk("sns_flags", 8'h20, flags.sensor_supply_short_flags);
    chk("sig_lim", 16'h0008, sig_lim);
    chk("sns_lim", 8'h20, sns_lim);
    chk("out_kept", 16'h0008, sop);
    rd_chk("sig_reg", REG_SIG_SHRT, 32'h8, RESP_OKAY);
    rd_chk("sns_reg", REG_SNS_SHRT, 32'h20, RESP_OKAY);
    @(posedge aclk);
    pins.signal_line_short   <= '0;
    pins.sensor_supply_short <= '0;
    settle(4);
    chk("short_clr", 32'h0, {flags.signal_line_short_flags, flags.sensor_supply_short_flags});
    chk("lim_clr", 32'h0, {sig_lim, sns_lim});
    u_net_master_model.set_remote(16'h0000);
  endtask : t_short

  // status holds every event so far; masked first, then cleared by w1c
  task automatic t_irq;
    chk("irq_masked", 32'h0, irq);
    axi_wr(REG_IRQ_MASK, 32'h1, 4'hf, RESP_OKAY);
    settle(1);
    chk("irq_on", 32'h1, irq);
    rd_chk("irq_st", REG_IRQ_ST, 32'h1f, RESP_OKAY);
    axi_wr(REG_IRQ_ST, 32'h3f, 4'hf, RESP_OKAY);
    settle(1);
    chk("irq_clr", 32'h0, irq);
    rd_chk("irq_st_clr", REG_IRQ_ST, 32'h0, RESP_OKAY);
    rd_chk("mask_rw", REG_IRQ_MASK, 32'h1, RESP_OKAY);
  endtask : t_irq

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_dir;
    t_out;
    t_count;
    t_supply;
    t_short;
    t_irq;
    print_verdict;
  end

  // the whole sequence needs well under two thousand cycles
  initial
  begin
    #(25 * 20000);
    error_cnt++;
    print_verdict;
  end
endmodule : sio_output_count_fault_flags_tb

// >>> logic/sio_output_count_fault_flags.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Function
// - output pins follow remote bits when output
// - later direction change latched on apply request
// - one 16-bit ON counter per output
// - counter wraps from 65535 to zero
// - counts kept across device swap, cleared power-up
// - write zero clears counter, read returns count
// - module supply low: flag and steady LED
// - actuator supply low: flag and flashing LED
// - actuator supply critical: flag and steady LED
// - actuator flags valid only with module supply
// - short engages current limit, output stays on
// - sensor supply short flagged at 1.6A
// - signal line short flagged at 3A
// - short sets signal and sensor short flags
// - monitoring always on, needs no setting
module sio_output_count_fault_flags
  import sio_pkg::*;
#(
  parameter logic [BLINK_W-1:0] BLINK_HALF = BLINK_W'(BLINK_HALF_CYCLES)
)
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [NUM_POINTS-1:0] remote_output_bits,
  input  wire logic [NUM_POINTS-1:0] channel_direction_select_bits,
  input  wire logic                  operating_condition_apply_request,
  input  wire logic                  initial_processing_active,
  input  wire det_pins_s             detector_pins,
  output logic [NUM_POINTS-1:0]      switched_output_points,
  output logic [NUM_POINTS-1:0]      output_direction,
  output logic [NUM_POINTS-1:0]      signal_line_limit,
  output logic [NUM_PORTS-1:0]       sensor_supply_limit,
  output fault_flags_s               fault_flags,
  output logic                       module_supply_led_red,
  output logic                       actuator_supply_led_red,
  output logic                       irq,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [AXI_AW-1:0]     awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [AXI_DW-1:0]     wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [AXI_AW-1:0]     araddr,
  input  wire logic [2:0]            arprot,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [AXI_DW-1:0]          rdata,
  output logic [1:0]                 rresp
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic reg_sel_e decode(input logic [AXI_AW-1:0] a);
    reg_sel_e s;
    s = SEL_NONE;
    if (a[PAGE_MSB:PAGE_LSB] == CNT_PAGE)
    begin
      s = SEL_CNT;
    end
    else
    begin
      unique case (a)
        REG_SUPPLY:   s = SEL_SUPPLY;
        REG_SIG_SHRT: s = SEL_SIG;
        REG_SNS_SHRT: s = SEL_SNS;
        REG_DIR:      s = SEL_DIR;
        REG_IRQ_ST:   s = SEL_IRQ_ST;
        REG_IRQ_MASK: s = SEL_IRQ_MASK;
        default:      s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decode

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  state_s                q;
  state_s                d;
  fault_flags_s          nf;
  logic [NUM_POINTS-1:0] on_rise;
  logic [NUM_POINTS-1:0] cnt_clr;
  logic [NUM_POINTS-1:0] cnt_max;
  logic [IRQ_W-1:0]      ev;
  logic                  wr_fire;
  reg_sel_e              wsel;
  reg_sel_e              rsel;
  logic [IDX_MSB-IDX_LSB:0] widx;

  // next flag values straight from the second sync stage, no enable bit
  always_comb
  begin
    nf.module_supply_low_flag        = q.sync2.module_sensor_supply_low;
    nf.actuator_supply_low_flag      = q.sync2.actuator_supply_low &
                                       ~q.sync2.module_sensor_supply_low;
    nf.actuator_supply_critical_flag = q.sync2.actuator_supply_critical &
                                       ~q.sync2.module_sensor_supply_low;
    nf.signal_line_short_flags       = q.sync2.signal_line_short;
    nf.sensor_supply_short_flags     = q.sync2.sensor_supply_short;
  end

  // register write fires once both address and data are held
  assign wr_fire = q.aw_v & q.w_v & ~q.b_v;
  assign wsel    = decode(q.aw_addr);
  assign rsel    = decode(araddr);
  assign widx    = q.aw_addr[IDX_MSB:IDX_LSB];
  assign on_rise = (q.dir & remote_output_bits) & ~q.drive;

  // per-output clear strobe and wrap detect
  for (genvar i = 0; i < NUM_POINTS; i++)
  begin : g_cnt
    assign cnt_clr[i] = wr_fire && (wsel == SEL_CNT) && (widx == (IDX_MSB - IDX_LSB + 1)'(i)) &&
                        ((q.w_strb & CNT_CLR_STRB) == CNT_CLR_STRB) &&
                        (q.w_data[CNT_W-1:0] == '0);
    assign cnt_max[i] = &q.cnt[i];
  end

  // interrupt events: new fault edges and counter wraps
  assign ev[IRQ_MOD]  = nf.module_supply_low_flag & ~q.flags.module_supply_low_flag;
  assign ev[IRQ_ACT]  = nf.actuator_supply_low_flag & ~q.flags.actuator_supply_low_flag;
  assign ev[IRQ_CRIT] = nf.actuator_supply_critical_flag & ~q.flags.actuator_supply_critical_flag;
  assign ev[IRQ_SIG]  = |(nf.signal_line_short_flags & ~q.flags.signal_line_short_flags);
  assign ev[IRQ_SNS]  = |(nf.sensor_supply_short_flags & ~q.flags.sensor_supply_short_flags);
  assign ev[IRQ_WRAP] = |(on_rise & cnt_max & ~cnt_clr);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    // detector pins come from the analog side, two flops before use
    d.sync1 = detector_pins;
    d.sync2 = q.sync1;
    d.flags = nf;

    // direction follows select bits during initial processing, then only on apply
    if (initial_processing_active)
    begin
      d.dir = channel_direction_select_bits;
    end
    else if (operating_condition_apply_request && !q.apply_prev)
    begin
      d.dir = channel_direction_select_bits;
    end
    d.apply_prev = operating_condition_apply_request;
    // shorts do not drop the output; the driver limits current instead
    d.drive = q.dir & remote_output_bits;

    // ON counters: only reset and a zero write clear them
    for (int i = 0; i < NUM_POINTS; i++)
    begin
      if (cnt_clr[i])
      begin
        d.cnt[i] = '0;
      end
      else if (on_rise[i])
      begin
        d.cnt[i] = q.cnt[i] + CNT_W'(1);
      end
    end

    // led blink base; free running so all flashing leds stay in phase
    if (q.blink_cnt >= BLINK_HALF - BLINK_W'(1))
    begin
      d.blink_cnt = '0;
      d.blink     = ~q.blink;
    end
    else
    begin
      d.blink_cnt = q.blink_cnt + BLINK_W'(1);
    end
    d.mod_led = nf.module_supply_low_flag;
    d.act_led = nf.actuator_supply_critical_flag |
                (nf.actuator_supply_low_flag & q.blink);

    // sticky status: a new event beats a same-cycle clear
    d.irq_st = q.irq_st;
    if (wr_fire && wsel == SEL_IRQ_ST)
    begin
      d.irq_st = q.irq_st & ~q.w_data[IRQ_W-1:0];
    end
    d.irq_st = d.irq_st | ev;
    if (wr_fire && wsel == SEL_IRQ_MASK)
    begin
      d.irq_mask = q.w_data[IRQ_W-1:0];
    end

    // write channel capture, either order
    if (awvalid && awready)
    begin
      d.aw_v    = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      d.w_v    = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (wr_fire)
    begin
      d.aw_v   = 1'b0;
      d.w_v    = 1'b0;
      d.b_v    = 1'b1;
      d.b_resp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.b_v && bready)
    begin
      d.b_v = 1'b0;
    end

    // read channel: data captured at the address handshake
    if (q.r_v && rready)
    begin
      d.r_v = 1'b0;
    end
    if (arvalid && arready)
    begin
      d.r_v    = 1'b1;
      d.r_resp = RESP_OKAY;
      d.r_data = '0;
      unique case (rsel)
        SEL_SUPPLY:
        begin
          d.r_data[SUP_MOD_BIT]  = q.flags.module_supply_low_flag;
          d.r_data[SUP_ACT_BIT]  = q.flags.actuator_supply_low_flag;
          d.r_data[SUP_CRIT_BIT] = q.flags.actuator_supply_critical_flag;
        end
        SEL_SIG:      d.r_data[NUM_POINTS-1:0] = q.flags.signal_line_short_flags;
        SEL_SNS:      d.r_data[NUM_PORTS-1:0]  = q.flags.sensor_supply_short_flags;
        SEL_DIR:      d.r_data[NUM_POINTS-1:0] = q.dir;
        SEL_IRQ_ST:   d.r_data[IRQ_W-1:0]      = q.irq_st;
        SEL_IRQ_MASK: d.r_data[IRQ_W-1:0]      = q.irq_mask;
        SEL_CNT:      d.r_data[CNT_W-1:0]      = q.cnt[araddr[IDX_MSB:IDX_LSB]];
        SEL_NONE:     d.r_resp                 = RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= STATE_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign switched_output_points  = q.drive;
  assign output_direction        = q.dir;
  assign signal_line_limit       = q.flags.signal_line_short_flags;
  assign sensor_supply_limit     = q.flags.sensor_supply_short_flags;
  assign fault_flags             = q.flags;
  assign module_supply_led_red   = q.mod_led;
  assign actuator_supply_led_red = q.act_led;
  assign irq                     = |(q.irq_st & q.irq_mask);
  assign awready                 = ~q.aw_v & ~q.b_v;
  assign wready                  = ~q.w_v & ~q.b_v;
  assign bvalid                  = q.b_v;
  assign bresp                   = q.b_resp;
  assign arready                 = ~q.r_v;
  assign rvalid                  = q.r_v;
  assign rdata                   = q.r_data;
  assign rresp                   = q.r_resp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence apply_edge;
    !initial_processing_active && operating_condition_apply_request && !q.apply_prev;
  endsequence

  sequence module_low_held;
    detector_pins.module_sensor_supply_low [*3];
  endsequence

  sequence write_both_held;
    q.aw_v && q.w_v && !q.b_v;
  endsequence

  out_follow_a: assert property (
    ##1 switched_output_points == ($past(output_direction) & $past(remote_output_bits)))
    else $error("output pins do not follow remote bits");

  dir_latch_a: assert property (
    apply_edge |=> output_direction == $past(channel_direction_select_bits))
    else $error("direction not latched on apply request");

  dir_hold_a: assert property (
    !initial_processing_active && !(operating_condition_apply_request && !q.apply_prev)
      |=> $stable(output_direction))
    else $error("direction changed without apply request");

  for (genvar i = 0; i < NUM_POINTS; i++)
  begin : g_chk
    cnt_step_a: assert property (
      on_rise[i] && !cnt_clr[i] && !cnt_max[i] |=> q.cnt[i] == $past(q.cnt[i]) + CNT_W'(1))
      else $error("counter did not step on output ON");
    cnt_wrap_a: assert property (
      on_rise[i] && !cnt_clr[i] && cnt_max[i] |=> q.cnt[i] == '0)
      else $error("counter did not wrap to zero");
    cnt_clear_a: assert property (
      cnt_clr[i] |=> q.cnt[i] == '0 ##1 (on_rise[i] || $stable(q.cnt[i])))
      else $error("counter not cleared by zero write");
  end

  supply_flag_a: assert property (
    module_low_held |=> fault_flags.module_supply_low_flag && module_supply_led_red)
    else $error("module supply low not flagged in time");

  act_gate_a: assert property (
    q.sync2.module_sensor_supply_low |=> !fault_flags.actuator_supply_low_flag &&
                                         !fault_flags.actuator_supply_critical_flag)
    else $error("actuator flags set while module supply low");

  crit_led_a: assert property (
    fault_flags.actuator_supply_critical_flag |-> actuator_supply_led_red)
    else $error("critical actuator supply led not steady");

  short_release_a: assert property (
    q.sync2.signal_line_short == '0 && q.sync2.sensor_supply_short == '0
      |=> fault_flags.signal_line_short_flags == '0 && sensor_supply_limit == '0)
    else $error("short flags did not release");

  irq_raise_a: assert property (
    ev[IRQ_MOD] && q.irq_mask[IRQ_MOD] |=> irq && q.irq_st[IRQ_MOD])
    else $error("event did not raise interrupt");

  write_resp_a: assert property (
    write_both_held |=> bvalid && !awready && !wready)
    else $error("write response missing");

endmodule : sio_output_count_fault_flags

// >>> logic/sio_pkg.sv
package sio_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_POINTS = 16;
  localparam int NUM_PORTS  = 8;
  localparam int CNT_W      = 16;
  localparam int AXI_AW     = 8;
  localparam int AXI_DW     = 32;
  localparam int IRQ_W      = 6;
  localparam int BLINK_W    = 24;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 40_000_000;
  localparam int LED_BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYCLES = LED_BLINK_HALF_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [AXI_AW-1:0] REG_SUPPLY   = 8'h00;
  localparam logic [AXI_AW-1:0] REG_SIG_SHRT = 8'h04;
  localparam logic [AXI_AW-1:0] REG_SNS_SHRT = 8'h08;
  localparam logic [AXI_AW-1:0] REG_DIR      = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_IRQ_ST   = 8'h10;
  localparam logic [AXI_AW-1:0] REG_IRQ_MASK = 8'h14;
  localparam logic [1:0]        CNT_PAGE     = 2'h1;   // 0x40..0x7c
  localparam int                PAGE_LSB     = 6;
  localparam int                PAGE_MSB     = 7;
  localparam int                IDX_LSB      = 2;
  localparam int                IDX_MSB      = 5;
  localparam logic [3:0]        CNT_CLR_STRB = 4'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SUP_MOD_BIT  = 0;
  localparam int SUP_ACT_BIT  = 1;
  localparam int SUP_CRIT_BIT = 2;
  localparam int IRQ_MOD      = 0;
  localparam int IRQ_ACT      = 1;
  localparam int IRQ_CRIT     = 2;
  localparam int IRQ_SIG      = 3;
  localparam int IRQ_SNS      = 4;
  localparam int IRQ_WRAP     = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_SUPPLY, SEL_SIG, SEL_SNS, SEL_DIR, SEL_IRQ_ST, SEL_IRQ_MASK, SEL_CNT, SEL_NONE
  } reg_sel_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  module_sensor_supply_low;
    logic                  actuator_supply_low;
    logic                  actuator_supply_critical;
    logic [NUM_POINTS-1:0] signal_line_short;
    logic [NUM_PORTS-1:0]  sensor_supply_short;
  } det_pins_s;

  typedef struct packed {
    logic                  module_supply_low_flag;
    logic                  actuator_supply_low_flag;
    logic                  actuator_supply_critical_flag;
    logic [NUM_POINTS-1:0] signal_line_short_flags;
    logic [NUM_PORTS-1:0]  sensor_supply_short_flags;
  } fault_flags_s;

  typedef struct packed {
    det_pins_s                         sync1;
    det_pins_s                         sync2;
    logic [NUM_POINTS-1:0]             dir;
    logic [NUM_POINTS-1:0]             drive;
    logic [NUM_POINTS-1:0][CNT_W-1:0]  cnt;
    logic                              apply_prev;
    fault_flags_s                      flags;
    logic                              mod_led;
    logic                              act_led;
    logic                              blink;
    logic [BLINK_W-1:0]                blink_cnt;
    logic [IRQ_W-1:0]                  irq_st;
    logic [IRQ_W-1:0]                  irq_mask;
    logic                              aw_v;
    logic [AXI_AW-1:0]                 aw_addr;
    logic                              w_v;
    logic [AXI_DW-1:0]                 w_data;
    logic [3:0]                        w_strb;
    logic                              b_v;
    logic [1:0]                        b_resp;
    logic                              r_v;
    logic [AXI_DW-1:0]                 r_data;
    logic [1:0]                        r_resp;
  } state_s;

  localparam state_s STATE_RST = '0;

endpackage : sio_pkg
